// ===== uar_pkg.sv
// constants, types and field layout of the single-pin serial port
package uar_pkg;

	// ===================================================================
	// register offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_SCLEAR  = 8'h08;
	localparam logic [7:0] OFF_IENABLE = 8'h0c;
	localparam logic [7:0] OFF_IDISABL = 8'h10;
	localparam logic [7:0] OFF_IMASK   = 8'h14;
	localparam logic [7:0] OFF_RXHOLD  = 8'h18;
	localparam logic [7:0] OFF_TXHOLD  = 8'h1c;
	localparam logic [7:0] OFF_BAUD    = 8'h20;
	localparam logic [7:0] OFF_VERSION = 8'h24;
	localparam logic [7:0] OFF_CLKREQ  = 8'h28;

	// ===================================================================
	// field positions and reset values
	localparam int          BIT_BUSY      = 0;
	localparam int          BIT_OSC       = 2;
	localparam int          BIT_READY     = 8;
	localparam int          BIT_DRDY      = 9;
	localparam int          BIT_OVERRUN   = 10;
	localparam int          BIT_CONFLICT  = 13;
	localparam logic [31:0] VERSION_RESET = 32'h0000_0210;
	localparam logic [15:0] DIVISOR_RESET = 16'h0000;
	localparam logic [7:0]  SYNC_BYTE     = 8'h55;
	// busy count loaded by a write; unless a frame is being sent, the cross-domain handshake is held busy one cycle longer than this
	localparam logic [2:0]  SYNC_CYCLES   = 3'h4;
	// falling edges of the sync byte that follow its start edge
	localparam logic [2:0]  SYNC_FALLS    = 3'h4;
	localparam logic [2:0]  LAST_BIT      = 3'h7;

	// ===================================================================
	// types
	typedef enum logic [1:0] {MODE_OFF, MODE_RX, MODE_TX, MODE_RXSYNC} uar_mode_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uar_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_MEASURE} uar_rx_st_t;

	typedef struct packed {
		logic conflict;
		logic overrun;
		logic dataReady;
		logic ready;
	} uar_flags_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wrData;
		logic        write;
		logic        read;
	} uar_bus_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} uar_pin_drv_t;

endpackage : uar_pkg

// ===== uar_single_pin_uart.sv
// single-pin asynchronous receiver/transmitter with its register file
`timescale 1ns/10ps
`default_nettype none

module uar_single_pin_uart (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	// serial pin
	input  wire logic        lineIn,
	output logic             lineOut,
	output logic             lineOe,
	// oscillator handshake
	input  wire logic        oscRunning,
	output logic             oscRequest,
	// interrupt
	output logic             irq
);

	// ===================================================================
	// state
	typedef struct packed {
		uar_pkg::uar_mode_t   mode;
		logic [15:0]          divisor;
		logic                 oscReq;
		uar_pkg::uar_flags_t  flags;
		uar_pkg::uar_flags_t  mask;
		logic [7:0]           rxByte;
		logic                 rxUnread;
		logic [7:0]           txByte;
		logic                 busy;
		logic [2:0]           busyCnt;
		uar_pkg::uar_tx_st_t  txSt;
		logic [7:0]           txShift;
		logic [2:0]           txBits;
		logic [12:0]          txCnt;
		uar_pkg::uar_rx_st_t  rxSt;
		logic [7:0]           rxShift;
		logic [2:0]           rxBits;
		logic [15:0]          rxCnt;
		logic [2:0]           falls;
		logic                 linePrev;
		logic                 synced;
		logic [31:0]          rdData;
		uar_pkg::uar_pin_drv_t pin;
		logic                 irq;
	} uar_state_t;

	uar_state_t          s;
	uar_state_t          next_s;
	uar_pkg::uar_bus_req_t bus;
	logic                rxDeliver;
	logic                conflictSet;
	logic                syncDone;
	logic [12:0]         bitCycles;
	logic                fallEdge;

	assign bus = '{addr: regAddr, wrData: regWrData, write: regWrite, read: regRead};

	// ===================================================================
	// helpers
	function automatic logic [31:0] flagsToWord(input uar_pkg::uar_flags_t f);
		logic [31:0] w;
		w                        = 32'h0000_0000;
		w[uar_pkg::BIT_CONFLICT] = f.conflict;
		w[uar_pkg::BIT_OVERRUN]  = f.overrun;
		w[uar_pkg::BIT_DRDY]     = f.dataReady;
		w[uar_pkg::BIT_READY]    = f.ready;
		return w;
	endfunction : flagsToWord

	function automatic uar_pkg::uar_flags_t wordToFlags(input logic [31:0] w);
		uar_pkg::uar_flags_t f;
		f.conflict  = w[uar_pkg::BIT_CONFLICT];
		f.overrun   = w[uar_pkg::BIT_OVERRUN];
		f.dataReady = w[uar_pkg::BIT_DRDY];
		f.ready     = w[uar_pkg::BIT_READY];
		return f;
	endfunction : wordToFlags

	// ===================================================================
	// next state
	always_comb begin
		uar_pkg::uar_flags_t setF;
		uar_pkg::uar_flags_t clrF;
		logic                wrOk;
		logic [31:0]         rd;
		next_s      = s;
		setF        = '0;
		clrF        = '0;
		rxDeliver   = 1'b0;
		syncDone    = 1'b0;
		rd          = 32'h0000_0000;
		// divisor is in eighths of a bit; a zero divisor still yields one cycle
		bitCycles   = (s.divisor[15:3] == 13'h0000) ? 13'h0001 : s.divisor[15:3];
		fallEdge    = s.linePrev & ~lineIn;
		wrOk        = bus.write & ~s.busy;
		conflictSet = (s.txSt != uar_pkg::TX_IDLE) & s.pin.out & ~lineIn;
		next_s.linePrev = lineIn;

		// register writes
		if (bus.write) begin
			unique case (bus.addr)
				uar_pkg::OFF_CTRL: if (wrOk) begin
					next_s.mode = uar_pkg::uar_mode_t'(bus.wrData[1:0]);
					if (bus.wrData[1:0] == 2'h0) begin
						next_s.synced = 1'b0;
						next_s.rxSt   = uar_pkg::RX_IDLE;
					end
				end
				uar_pkg::OFF_SCLEAR:  clrF = wordToFlags(bus.wrData);
				uar_pkg::OFF_IENABLE: next_s.mask = s.mask | wordToFlags(bus.wrData);
				uar_pkg::OFF_IDISABL: next_s.mask = s.mask & ~wordToFlags(bus.wrData);
				uar_pkg::OFF_BAUD:    if (wrOk) next_s.divisor = bus.wrData[15:0];
				uar_pkg::OFF_CLKREQ:  next_s.oscReq = bus.wrData[0];
				uar_pkg::OFF_TXHOLD:  if (wrOk) next_s.txByte = bus.wrData[7:0];
				default: ;
			endcase
			if (wrOk && (bus.addr == uar_pkg::OFF_CTRL || bus.addr == uar_pkg::OFF_BAUD
					|| bus.addr == uar_pkg::OFF_TXHOLD)) begin
				next_s.busy    = 1'b1;
				next_s.busyCnt = uar_pkg::SYNC_CYCLES;
			end
			if (wrOk && bus.addr == uar_pkg::OFF_TXHOLD && s.mode == uar_pkg::MODE_TX) begin
				next_s.txSt    = uar_pkg::TX_START;
				next_s.txShift = bus.wrData[7:0];
				next_s.txCnt   = bitCycles - 13'h0001;
				next_s.txBits  = 3'h0;
				next_s.pin     = '{out: 1'b0, oe: 1'b1};
			end
		end

		// register reads, data stand one cycle only
		if (bus.read) begin
			unique case (bus.addr)
				uar_pkg::OFF_CTRL:    rd = {30'h0, s.mode};
				uar_pkg::OFF_STATUS: begin
					rd                  = flagsToWord(s.flags);
					rd[uar_pkg::BIT_BUSY] = s.busy;
					rd[uar_pkg::BIT_OSC]  = oscRunning;
				end
				uar_pkg::OFF_IMASK:   rd = flagsToWord(s.mask);
				uar_pkg::OFF_RXHOLD: begin
					rd              = {24'h0, s.rxByte};
					next_s.rxUnread = 1'b0;
				end
				uar_pkg::OFF_TXHOLD:  rd = {24'h0, s.txByte};
				uar_pkg::OFF_BAUD:    rd = {16'h0, s.divisor};
				uar_pkg::OFF_VERSION: rd = uar_pkg::VERSION_RESET;
				uar_pkg::OFF_CLKREQ:  rd = {31'h0, s.oscReq};
				default:              rd = 32'h0000_0000;
			endcase
		end
		next_s.rdData = rd;

		// transmitter
		if (s.txSt != uar_pkg::TX_IDLE) begin
			if (s.txCnt != 13'h0000) begin
				next_s.txCnt = s.txCnt - 13'h0001;
			end else begin
				next_s.txCnt = bitCycles - 13'h0001;
				unique case (s.txSt)
					uar_pkg::TX_START: begin
						next_s.txSt    = uar_pkg::TX_DATA;
						next_s.pin.out = s.txShift[0];
						next_s.txShift = {1'b1, s.txShift[7:1]};
					end
					uar_pkg::TX_DATA: begin
						if (s.txBits == uar_pkg::LAST_BIT) begin
							next_s.txSt    = uar_pkg::TX_STOP;
							next_s.pin.out = 1'b1;
						end else begin
							next_s.pin.out = s.txShift[0];
							next_s.txShift = {1'b1, s.txShift[7:1]};
						end
						next_s.txBits = s.txBits + 3'h1;
					end
					default: begin
						next_s.txSt = uar_pkg::TX_IDLE;
						next_s.pin  = '{out: 1'b1, oe: 1'b0};
					end
				endcase
			end
		end

		// receiver: sampling points are the middle of each bit
		unique case (s.rxSt)
			uar_pkg::RX_IDLE: begin
				if (fallEdge && s.mode == uar_pkg::MODE_RXSYNC && !s.synced) begin
					next_s.rxSt  = uar_pkg::RX_MEASURE;
					next_s.rxCnt = 16'h0000;
					next_s.falls = 3'h0;
				end else if (fallEdge && (s.mode == uar_pkg::MODE_RX
						|| s.mode == uar_pkg::MODE_RXSYNC)) begin
					next_s.rxSt  = uar_pkg::RX_START;
					next_s.rxCnt = {3'h0, bitCycles >> 1};
				end
			end
			uar_pkg::RX_MEASURE: begin
				// start edge to fifth falling edge of 0x55 spans eight bits,
				// which in eighths of a bit is the divisor itself
				next_s.rxCnt = s.rxCnt + 16'h0001;
				if (fallEdge) begin
					next_s.falls = s.falls + 3'h1;
					if (s.falls + 3'h1 == uar_pkg::SYNC_FALLS) begin
						syncDone       = 1'b1;
						next_s.divisor = s.rxCnt + 16'h0001;
						next_s.synced  = 1'b1;
						next_s.rxSt    = uar_pkg::RX_IDLE;
					end
				end
			end
			default: begin
				if (s.rxCnt != 16'h0000) begin
					next_s.rxCnt = s.rxCnt - 16'h0001;
				end else begin
					next_s.rxCnt = {3'h0, bitCycles} - 16'h0001;
					unique case (s.rxSt)
						uar_pkg::RX_START: begin
							next_s.rxSt   = lineIn ? uar_pkg::RX_IDLE : uar_pkg::RX_DATA;
							next_s.rxBits = 3'h0;
						end
						uar_pkg::RX_DATA: begin
							next_s.rxShift = {lineIn, s.rxShift[7:1]};
							next_s.rxBits  = s.rxBits + 3'h1;
							if (s.rxBits == uar_pkg::LAST_BIT) next_s.rxSt = uar_pkg::RX_STOP;
						end
						default: begin
							// a byte with a low stop bit is dropped
							next_s.rxSt = uar_pkg::RX_IDLE;
							rxDeliver   = lineIn;
						end
					endcase
				end
			end
		endcase
		if (s.mode != uar_pkg::MODE_RX && s.mode != uar_pkg::MODE_RXSYNC)
			next_s.rxSt = uar_pkg::RX_IDLE;
		// a sync finishing in the cycle of a disabling write is cleared one cycle later, once the mode reads off
		if (s.mode == uar_pkg::MODE_OFF)
			next_s.synced = 1'b0;
		if (rxDeliver) begin
			next_s.rxByte   = s.rxShift;
			next_s.rxUnread = 1'b1;
			setF.dataReady  = 1'b1;
			setF.overrun    = s.rxUnread;
		end

		// busy handshake: a transmit keeps it busy until the frame ends
		if (s.busy) begin
			if (s.busyCnt != 3'h0) begin
				next_s.busyCnt = s.busyCnt - 3'h1;
			end else if (next_s.txSt == uar_pkg::TX_IDLE) begin
				next_s.busy = 1'b0;
				setF.ready  = 1'b1;
			end
		end

		setF.conflict = conflictSet;
		// a set in the same cycle as its clear wins
		next_s.flags  = (s.flags & ~clrF) | setF;
		next_s.irq    = |(next_s.flags & next_s.mask);
	end

	// ===================================================================
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			s          <= '0;
			s.divisor  <= uar_pkg::DIVISOR_RESET;
			s.linePrev <= 1'b1;
			s.pin      <= '{out: 1'b1, oe: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign regRdData  = s.rdData;
	assign lineOut    = s.pin.out;
	assign lineOe     = s.pin.oe;
	assign oscRequest = s.oscReq;
	assign irq        = s.irq;

	// ===================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence txStarts;
		$rose(s.txSt != uar_pkg::TX_IDLE);
	endsequence

	sequence frameEnds;
		$fell(s.pin.oe);
	endsequence

	tx_mode_only_a: assert property (txStarts |-> $past(s.mode) == uar_pkg::MODE_TX)
		else $error("transmit started outside transmit mode");
	conflict_set_a: assert property (conflictSet |=> s.flags.conflict)
		else $error("conflict flag not set");
	overrun_set_a: assert property (rxDeliver && s.rxUnread |=> s.flags.overrun)
		else $error("overrun flag not set");
	data_ready_a: assert property (rxDeliver
			|=> s.flags.dataReady && s.rxByte == $past(s.rxShift))
		else $error("received byte not delivered");
	ready_on_idle_a: assert property ($fell(s.busy) |-> s.flags.ready)
		else $error("ready flag missing after busy");
	osc_status_a: assert property (bus.read && bus.addr == uar_pkg::OFF_STATUS
			|=> regRdData[uar_pkg::BIT_OSC] == $past(oscRunning))
		else $error("oscillator status wrong");
	busy_blocks_a: assert property (bus.write && bus.addr == uar_pkg::OFF_BAUD && s.busy
			&& s.rxSt != uar_pkg::RX_MEASURE |=> $stable(s.divisor))
		else $error("baud write taken while busy");
	flag_clear_a: assert property (bus.write && bus.addr == uar_pkg::OFF_SCLEAR
			&& bus.wrData[uar_pkg::BIT_CONFLICT] && !conflictSet |=> !s.flags.conflict)
		else $error("conflict flag not cleared");
	mask_set_a: assert property (bus.write && bus.addr == uar_pkg::OFF_IENABLE
			&& bus.wrData[uar_pkg::BIT_DRDY] |=> s.mask.dataReady)
		else $error("mask bit not set");
	mask_clear_a: assert property (bus.write && bus.addr == uar_pkg::OFF_IDISABL
			&& bus.wrData[uar_pkg::BIT_CONFLICT] |=> !s.mask.conflict)
		else $error("mask bit not cleared");
	mask_read_a: assert property (bus.read && bus.addr == uar_pkg::OFF_IMASK
			|=> regRdData == flagsToWord($past(s.mask)))
		else $error("mask readback wrong");
	frame_shape_a: assert property ((txStarts |-> !s.pin.out)
			and (frameEnds |-> $past(s.pin.out)))
		else $error("start or stop bit wrong");
	irq_raise_a: assert property ($rose(|(s.flags & s.mask)) |-> s.irq)
		else $error("interrupt not raised");
	sync_load_a: assert property (syncDone
			|=> s.synced && s.divisor == $past(s.rxCnt) + 16'h0001)
		else $error("divisor not loaded from sync byte");
	// refused writes must leave the guarded state untouched
	ctrl_blocked_a: assert property (bus.write && bus.addr == uar_pkg::OFF_CTRL && s.busy
			|=> $stable(s.mode))
		else $error("control write taken while busy");
	tx_blocked_a: assert property (bus.write && bus.addr == uar_pkg::OFF_TXHOLD && s.busy
			|=> $stable(s.txByte))
		else $error("transmit write taken while busy");
	busy_in_frame_a: assert property (s.txSt != uar_pkg::TX_IDLE |-> s.busy)
		else $error("frame running while not busy");
	status_busy_a: assert property (bus.read && bus.addr == uar_pkg::OFF_STATUS
			|=> regRdData[uar_pkg::BIT_BUSY] == $past(s.busy))
		else $error("busy status wrong");
	ready_source_a: assert property ($rose(s.flags.ready) |-> $fell(s.busy))
		else $error("ready flag without busy end");
	overrun_hold_a: assert property (s.flags.overrun && !(bus.write
			&& bus.addr == uar_pkg::OFF_SCLEAR && bus.wrData[uar_pkg::BIT_OVERRUN])
			|=> s.flags.overrun)
		else $error("overrun flag lost");
	rx_off_idle_a: assert property (s.mode == uar_pkg::MODE_OFF
			|=> s.rxSt == uar_pkg::RX_IDLE && !s.synced)
		else $error("receiver active while disabled");

endmodule : uar_single_pin_uart

`default_nettype wire

// ===== uar_far_party.sv
// remote serial party on the shared pin: sends, receives and jams 8N1 characters
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// far party
module uar_far_party (
	// clock
	input  wire logic clk,
	// pin
	input  wire logic lineLevel,
	output var logic  farLow
);
	initial farLow = 1'b0;

	// samples land 1 ns after the edge so pin updates of that edge are seen
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// released pin floats high through the pull-up, so a one is never driven
	task automatic send_byte(input logic [7:0] b, input int t);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk) farLow <= ~frame[i];
			repeat (t - 1) @(posedge clk);
		end
	endtask : send_byte

	task automatic recv_byte(input int t, output logic [7:0] b, output logic ok);
		ok = 1'b0;
		b = 8'h00;
		for (int n = 0; n < 200 && !ok; n++) begin
			tick(1);
			ok = !lineLevel;
		end
		tick(t / 2);
		ok = ok & !lineLevel;
		for (int i = 0; i < 8; i++) begin
			tick(t);
			b[i] = lineLevel;
		end
		tick(t);
		ok = ok & lineLevel;
	endtask : recv_byte

	task automatic jam(input int n);
		@(posedge clk) farLow <= 1'b1;
		repeat (n) @(posedge clk);
		farLow <= 1'b0;
	endtask : jam
endmodule : uar_far_party
`default_nettype wire

// ===== tb_single_pin_uart_regs.sv
// self-checking bench of the single-pin serial port and its registers
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// bench
module tb_single_pin_uart_regs;
	logic        clk;
	logic        rst;
	logic [7:0]  regAddr;
	logic [31:0] regWrData;
	logic        regWrite;
	logic        regRead;
	logic [31:0] regRdData;
	logic        lineOut;
	logic        lineOe;
	logic        oscRunning;
	logic        oscRequest;
	logic        irq;
	logic        farLow;
	logic        lineLevel;
	int          n_errors;
	int          check_count;

	// wired-and pin with pull-up
	assign lineLevel = !((lineOe && !lineOut) || farLow);

	uar_single_pin_uart i_dut (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .lineIn(lineLevel), .lineOut(lineOut),
		.lineOe(lineOe), .oscRunning(oscRunning), .oscRequest(oscRequest),
		.irq(irq));

	uar_far_party i_far (.clk(clk), .lineLevel(lineLevel), .farLow(farLow));

	// ==========================================================
	// bus and compare tasks
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask : rd

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(d, exp);
	endtask : expect_reg

	// a hung handshake is a mismatch and ends the run
	task automatic wait_idle();
		logic [31:0] d;
		for (int n = 0; n < 300; n++) begin
			rd(uar_pkg::OFF_STATUS, d);
			if (d[uar_pkg::BIT_BUSY] === 1'b0) return;
		end
		n_errors++;
		end_sim();
	endtask : wait_idle

	// ==========================================================
	// scenarios
	task automatic test_reset();
		expect_reg(uar_pkg::OFF_CTRL, 32'h0);
		expect_reg(uar_pkg::OFF_STATUS, 32'h0);
		expect_reg(uar_pkg::OFF_IMASK, 32'h0);
		expect_reg(uar_pkg::OFF_RXHOLD, 32'h0);
		expect_reg(uar_pkg::OFF_TXHOLD, 32'h0);
		expect_reg(uar_pkg::OFF_BAUD, 32'h0);
		expect_reg(uar_pkg::OFF_VERSION, uar_pkg::VERSION_RESET);
		expect_reg(uar_pkg::OFF_CLKREQ, 32'h0);
		expect_reg(8'h30, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("test reset done");
	endtask : test_reset

	task automatic test_osc();
		wr(uar_pkg::OFF_CLKREQ, 32'h1);
		expect_reg(uar_pkg::OFF_CLKREQ, 32'h1);
		check({31'h0, oscRequest}, 32'h1);
		expect_reg(uar_pkg::OFF_STATUS, 32'h0);
		@(posedge clk) oscRunning <= 1'b1;
		expect_reg(uar_pkg::OFF_STATUS, 32'h4);
		$display("test osc done");
	endtask : test_osc

	// a baud write right behind a control write must be dropped
	task automatic test_busy();
		wr(uar_pkg::OFF_CTRL, 32'h2);
		wr(uar_pkg::OFF_BAUD, 32'h20);
		expect_reg(uar_pkg::OFF_STATUS, 32'h5);
		wait_idle();
		expect_reg(uar_pkg::OFF_BAUD, 32'h0);
		expect_reg(uar_pkg::OFF_STATUS, 32'h104);
		expect_reg(uar_pkg::OFF_CTRL, 32'h2);
		wr(uar_pkg::OFF_BAUD, 32'h20);
		wait_idle();
		expect_reg(uar_pkg::OFF_BAUD, 32'h20);
		wr(uar_pkg::OFF_SCLEAR, 32'h2700);
		expect_reg(uar_pkg::OFF_STATUS, 32'h4);
		$display("test busy done");
	endtask : test_busy

	task automatic test_tx();
		logic [7:0] b;
		logic       ok;
		fork
			wr(uar_pkg::OFF_TXHOLD, 32'ha5);
			i_far.recv_byte(4, b, ok);
		join
		check({23'h0, ok, b}, 32'h1a5);
		check({31'h0, lineOe}, 32'h1);
		wait_idle();
		check({31'h0, lineOe}, 32'h0);
		wr(uar_pkg::OFF_SCLEAR, 32'h2700);
		expect_reg(uar_pkg::OFF_STATUS, 32'h4);
		fork
			begin
				wr(uar_pkg::OFF_TXHOLD, 32'hff);
				wr(uar_pkg::OFF_TXHOLD, 32'h00);
				wr(uar_pkg::OFF_CTRL, 32'h1);
			end
			begin
				repeat (12) @(posedge clk);
				i_far.jam(8);
			end
		join
		wait_idle();
		expect_reg(uar_pkg::OFF_STATUS, 32'h2104);
		expect_reg(uar_pkg::OFF_TXHOLD, 32'hff);
		expect_reg(uar_pkg::OFF_CTRL, 32'h2);
		$display("test tx done");
	endtask : test_tx

	task automatic test_irq();
		wr(uar_pkg::OFF_IENABLE, 32'hffffffff);
		expect_reg(uar_pkg::OFF_IMASK, 32'h2700);
		check({31'h0, irq}, 32'h1);
		wr(uar_pkg::OFF_IDISABL, 32'h2000);
		expect_reg(uar_pkg::OFF_IMASK, 32'h0700);
		wr(uar_pkg::OFF_SCLEAR, 32'h0);
		expect_reg(uar_pkg::OFF_STATUS, 32'h2104);
		wr(uar_pkg::OFF_SCLEAR, 32'h100);
		expect_reg(uar_pkg::OFF_STATUS, 32'h2004);
		check({31'h0, irq}, 32'h0);
		wr(uar_pkg::OFF_IENABLE, 32'h2000);
		expect_reg(uar_pkg::OFF_IMASK, 32'h2700);
		check({31'h0, irq}, 32'h1);
		wr(uar_pkg::OFF_SCLEAR, 32'h2000);
		expect_reg(uar_pkg::OFF_STATUS, 32'h4);
		check({31'h0, irq}, 32'h0);
		$display("test irq done");
	endtask : test_irq

	task automatic test_rx();
		wr(uar_pkg::OFF_CTRL, 32'h1);
		wait_idle();
		check({31'h0, irq}, 32'h1);
		wr(uar_pkg::OFF_SCLEAR, 32'h100);
		i_far.send_byte(8'h3c, 4);
		i_far.tick(6);
		expect_reg(uar_pkg::OFF_STATUS, 32'h204);
		expect_reg(uar_pkg::OFF_RXHOLD, 32'h3c);
		i_far.send_byte(8'hc3, 4);
		i_far.send_byte(8'h81, 4);
		i_far.tick(6);
		expect_reg(uar_pkg::OFF_STATUS, 32'h604);
		expect_reg(uar_pkg::OFF_RXHOLD, 32'h81);
		$display("test rx done");
	endtask : test_rx

	// sync byte at six cycles a bit gives eight bit times edge to edge
	task automatic test_resync();
		wr(uar_pkg::OFF_CTRL, 32'h0);
		wait_idle();
		wr(uar_pkg::OFF_CTRL, 32'h3);
		wait_idle();
		i_far.send_byte(uar_pkg::SYNC_BYTE, 6);
		i_far.tick(8);
		expect_reg(uar_pkg::OFF_BAUD, 32'd48);
		i_far.send_byte(8'h5a, 6);
		i_far.tick(8);
		expect_reg(uar_pkg::OFF_RXHOLD, 32'h5a);
		expect_reg(uar_pkg::OFF_CTRL, 32'h3);
		$display("test resync done");
	endtask : test_resync

	// ==========================================================
	// clock, reset, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	initial begin
		n_errors = 0;
		check_count = 0;
		rst = 1'b1;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		oscRunning = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_osc();
		test_busy();
		test_tx();
		test_irq();
		test_rx();
		test_resync();
		end_sim();
	end
endmodule : tb_single_pin_uart_regs
`default_nettype wire
